//--- hdl/spi_flash_pkg.sv
// Purpose: shared constants for the serial flash slave front end and its bus master
// Assumes: the slave and master clocks both run at 250 MHz
// Notes: sck is sampled, never used as a clock
package spi_flash_pkg;
	// ==========================================================
	// opcodes
	localparam logic [7:0] OP_READ      = 8'h03;
	localparam logic [7:0] OP_SECT_ERA  = 8'h20;
	localparam logic [7:0] OP_BLK_ERA   = 8'h52;
	localparam logic [7:0] OP_CHIP_ERA  = 8'h60;
	localparam logic [7:0] OP_BYTE_PROG = 8'h02;
	localparam logic [7:0] OP_AUTO_PROG = 8'hAF;
	localparam logic [7:0] OP_RD_STAT   = 8'h05;
	localparam logic [7:0] OP_EN_WSTAT  = 8'h50;
	localparam logic [7:0] OP_WR_STAT   = 8'h01;
	localparam logic [7:0] OP_WR_EN     = 8'h06;
	localparam logic [7:0] OP_WR_DIS    = 8'h04;
	// ==========================================================
	// status register layout
	localparam int ST_BUSY = 0;
	localparam int ST_WEL  = 1;
	localparam int ST_BP0  = 2;
	localparam int ST_BP1  = 3;
	localparam int ST_AAI  = 6;
	localparam int ST_BPL  = 7;
	localparam logic [1:0] BP_RESET  = 2'h3;
	localparam logic [15:0] ADDR_TOP = 16'hFFFF;
	localparam logic [15:0] QUARTER_BASE = 16'hC000;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	// ==========================================================
	// memory geometry in address bits
	localparam int SECTOR_BITS = 12;
	localparam int BLOCK_BITS  = 15;
	// ==========================================================
	// operation kinds reported by the slave
	typedef enum logic [2:0] {
		OPK_PROG  = 3'b000,
		OPK_SECT  = 3'b001,
		OPK_BLOCK = 3'b010,
		OPK_CHIP  = 3'b011
	} op_kind_t;
	// ==========================================================
	// timing
	localparam int MCLK_PERIOD_NS = 4;
	localparam int SCK_PERIOD_NS  = 125;
	localparam int SCK_HALF_CYCLES = SCK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
	localparam int OP_CYCLES_DEF  = 64;
	// ==========================================================
	// master register offsets and fields
	localparam logic [1:0] REG_CTRL   = 2'h0;
	localparam logic [1:0] REG_DATA   = 2'h1;
	localparam logic [1:0] REG_STATUS = 2'h2;
	localparam int CTRL_SEL  = 0;
	localparam int CTRL_HOLD = 1;
	localparam int CTRL_WP   = 2;
	localparam int STAT_RUN  = 0;
	localparam int STAT_DONE = 1;
	localparam logic [2:0] CTRL_RESET = 3'h0;
endpackage : spi_flash_pkg

//--- hdl/spi_flash_if.sv
// Purpose: serial pins between the flash slave and its bus master
// Assumes: a released serial out shows the inverse of its last bit, so a late sample is caught
// Notes: no clocking block
`timescale 1ns/10ps
`default_nettype none
interface spi_flash_if;
	logic sck;
	logic ce_n;
	logic si;
	logic so;
	logic so_oe;
	logic hold_n;
	logic wp_n;
	wire  so_line;
	assign so_line = so_oe ? so : !so;
	modport dev (input sck, input ce_n, input si, input hold_n, input wp_n,
		output so, output so_oe);
	modport host (output sck, output ce_n, output si, output hold_n, output wp_n,
		input so_line);
endinterface : spi_flash_if
`default_nettype wire

//--- hdl/spi_flash_slave.sv
// Purpose: serial flash slave: framing, pause, status register, protection
// Assumes: all pins asynchronous to i_mclk; sck well below i_mclk / 8
// Notes: the array itself is not stored; reads return erased bytes
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module spi_flash_slave
	import spi_flash_pkg::*;
#(
	parameter int OP_CYCLES = OP_CYCLES_DEF
)(
	// clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_reset_n,
	// serial pins
	spi_flash_if.dev        spi,
	// user side
	output logic [7:0]      o_status,
	output logic            o_paused,
	output logic            o_op_valid,
	output op_kind_t        o_op_kind,
	output logic [15:0]     o_op_addr,
	output logic [7:0]      o_op_data
);
	initial
	begin
		if (OP_CYCLES < 2 || OP_CYCLES > 65535)
			$error("OP_CYCLES out of range");
	end

	// ==========================================================
	// state
	typedef struct packed {
		logic        ce_m, ce_s, ce_p;
		logic        sck_m, sck_s, sck_p;
		logic        si_m, si_s;
		logic        hold_m, hold_s;
		logic        wp_m, wp_s;
		logic        paused;
		logic [2:0]  bit_cnt;
		logic [2:0]  byte_cnt;
		logic [7:0]  shift;
		logic [7:0]  opcode;
		logic [15:0] addr;
		logic [7:0]  data;
		logic [7:0]  tx;
		logic        sending, so_live;
		logic        so;
		logic        so_oe;
		logic        write_enable_latch;
		logic [1:0]  bp;
		logic        protect_lockdown_bit;
		logic        auto_increment_program;
		logic        aai_last;
		logic [15:0] busy_cnt;
		logic        op_valid;
		op_kind_t    op_kind;
		logic [15:0] op_addr;
		logic [7:0]  op_data;
		logic [7:0]  status;
	} state_t;
	state_t q, d;
	// ==========================================================
	// protection decode
	function automatic logic is_protected(input logic [1:0] bp, input logic [15:0] a,
		input logic blk);
		case (bp)
			2'h0: is_protected = 1'b0;
			2'h1: is_protected = !blk && (a >= QUARTER_BASE);
			2'h2: is_protected = a[15];
			default: is_protected = 1'b1;
		endcase
	endfunction : is_protected
	function automatic logic [7:0] status_of(input state_t s);
		status_of = {s.protect_lockdown_bit, s.auto_increment_program, 2'b00, s.bp, s.write_enable_latch, |s.busy_cnt};
	endfunction : status_of
	logic       sck_rise, sck_fall, frame_end, busy, active;
	logic [7:0] rx_byte;
	logic [15:0] blk_addr, sect_addr;
	always_comb
	begin
		d = q;
		// two-flop synchronisers
		d.ce_m   = spi.ce_n;
		d.ce_s   = q.ce_m;
		d.ce_p   = q.ce_s;
		d.sck_m  = spi.sck;
		d.sck_s  = q.sck_m;
		d.sck_p  = q.sck_s;
		d.si_m   = spi.si;
		d.si_s   = q.si_m;
		d.hold_m = spi.hold_n;
		d.hold_s = q.hold_m;
		d.wp_m   = spi.wp_n;
		d.wp_s   = q.wp_m;
		d.op_valid = 1'b0;

		busy      = (q.busy_cnt != 16'h0000);
		sck_rise  = q.sck_s && !q.sck_p;
		sck_fall  = !q.sck_s && q.sck_p;
		frame_end = q.ce_s && !q.ce_p;
		active    = !q.ce_s && !q.paused;
		rx_byte   = {q.shift[6:0], q.si_s};
		blk_addr  = q.addr & ~16'((1 << BLOCK_BITS) - 1);
		sect_addr = q.addr & ~16'((1 << SECTOR_BITS) - 1);

		// pause state changes only while sck is low
		if (!q.sck_s)
			d.paused = !q.hold_s;
		if (busy)
		begin
			d.busy_cnt = q.busy_cnt - 16'h0001;
			// an auto-increment run keeps the latch until its last byte
			if (q.busy_cnt == 16'h0001 && (!q.auto_increment_program || q.aai_last))
			begin
				d.write_enable_latch = 1'b0;
				d.auto_increment_program = 1'b0;
			end
		end
		if (q.ce_s)
		begin
			// deselected: command logic idle
			d.bit_cnt  = 3'h0;
			d.byte_cnt = 3'h0;
			d.sending  = 1'b0;
			d.so_live  = 1'b0;
		end
		else if (active && sck_rise)
		begin
			d.shift   = rx_byte;
			d.bit_cnt = q.bit_cnt + 3'h1;
			if (q.bit_cnt == 3'h7)
			begin
				if (q.byte_cnt != 3'h5)
					d.byte_cnt = q.byte_cnt + 3'h1;
				if (q.byte_cnt == 3'h0)
					d.opcode = rx_byte;
				else if (q.byte_cnt <= 3'h3 && !(q.auto_increment_program && q.opcode == OP_AUTO_PROG))
					d.addr = {q.addr[7:0], rx_byte};
				d.data = rx_byte;
				if (q.byte_cnt == 3'h0 && rx_byte == OP_RD_STAT)
				begin
					d.tx      = status_of(q);
					d.sending = 1'b1;
				end
				else if (q.byte_cnt == 3'h3 && q.opcode == OP_READ && !busy)
				begin
					d.tx      = ERASED_BYTE;
					d.sending = 1'b1;
				end
			end
		end
		else if (active && sck_fall && q.sending)
		begin
			// status read refreshes its byte at every byte boundary
			d.tx      = (q.opcode == OP_RD_STAT && q.bit_cnt == 3'h0) ? status_of(q) : q.tx;
			d.so      = d.tx[7];
			d.tx      = {d.tx[6:0], d.tx[7]};
			d.so_live = 1'b1;
		end
		// commands take effect at the end of their frame
		if (frame_end && !busy && q.bit_cnt == 3'h0)
		begin
			case (q.opcode)
				OP_WR_EN:
					if (q.byte_cnt == 3'h1)
						d.write_enable_latch = 1'b1;
				OP_WR_DIS:
					if (q.byte_cnt == 3'h1)
					begin
						d.write_enable_latch = 1'b0;
						d.auto_increment_program = 1'b0;
					end
				OP_WR_STAT:
					// refused write leaves every bit as it was
					if (q.byte_cnt == 3'h2 && (q.wp_s || !q.protect_lockdown_bit))
					begin
						d.protect_lockdown_bit = q.data[ST_BPL];
						d.bp  = {q.data[ST_BP1], q.data[ST_BP0]};
					end
				OP_BYTE_PROG:
					if (q.byte_cnt == 3'h5 && q.write_enable_latch && !q.auto_increment_program
						&& !is_protected(q.bp, q.addr, 1'b0))
					begin
						d.busy_cnt = 16'(OP_CYCLES);
						d.op_valid = 1'b1;
						d.op_kind  = OPK_PROG;
						d.op_addr  = q.addr;
						d.op_data  = q.data;
					end
				OP_AUTO_PROG:
					if (q.write_enable_latch && ((!q.auto_increment_program && q.byte_cnt == 3'h5) || (q.auto_increment_program && q.byte_cnt == 3'h2))
						&& !is_protected(q.bp, q.addr, 1'b0))
					begin
						d.busy_cnt = 16'(OP_CYCLES);
						d.auto_increment_program      = 1'b1;
						d.aai_last = (q.addr == ADDR_TOP);
						d.addr     = q.addr + 16'h0001;
						d.op_valid = 1'b1;
						d.op_kind  = OPK_PROG;
						d.op_addr  = q.addr;
						d.op_data  = q.data;
					end
				OP_SECT_ERA:
					if (q.byte_cnt == 3'h4 && q.write_enable_latch && !q.auto_increment_program
						&& !is_protected(q.bp, sect_addr, 1'b0))
					begin
						d.busy_cnt = 16'(OP_CYCLES);
						d.op_valid = 1'b1;
						d.op_kind  = OPK_SECT;
						d.op_addr  = sect_addr;
					end
				OP_BLK_ERA:
					if (q.byte_cnt == 3'h4 && q.write_enable_latch && !q.auto_increment_program
						&& !is_protected(q.bp, blk_addr, 1'b1))
					begin
						d.busy_cnt = 16'(OP_CYCLES);
						d.op_valid = 1'b1;
						d.op_kind  = OPK_BLOCK;
						d.op_addr  = blk_addr;
					end
				OP_CHIP_ERA:
					if (q.byte_cnt == 3'h1 && q.write_enable_latch && !q.auto_increment_program && q.bp == 2'h0)
					begin
						d.busy_cnt = 16'(OP_CYCLES);
						d.op_valid = 1'b1;
						d.op_kind  = OPK_CHIP;
						d.op_addr  = 16'h0000;
					end
				default:
					d.op_valid = 1'b0;
			endcase
		end
		// released while paused or deselected; driven only from the first falling edge on
		d.so_oe  = !q.ce_s && q.so_live && !q.paused;
		d.status = status_of(d);
	end
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
		begin
			q          <= '0;
			q.ce_m     <= 1'b1;
			q.ce_s     <= 1'b1;
			q.ce_p     <= 1'b1;
			q.hold_m   <= 1'b1;
			q.hold_s   <= 1'b1;
			q.wp_m     <= 1'b1;
			q.wp_s     <= 1'b1;
			q.bp       <= BP_RESET;
			q.status   <= {4'h0, BP_RESET, 2'h0};
			q.protect_lockdown_bit      <= 1'b0;
			q.write_enable_latch      <= 1'b0;
		end
		else
			q <= d;
	end

	// ==========================================================
	// outputs
	assign spi.so     = q.so;
	assign spi.so_oe  = q.so_oe;
	assign o_status   = q.status;
	assign o_paused   = q.paused;
	assign o_op_valid = q.op_valid;
	assign o_op_kind  = q.op_kind;
	assign o_op_addr  = q.op_addr;
	assign o_op_data  = q.op_data;
endmodule : spi_flash_slave
`default_nettype wire

//--- hdl/spi_flash_master.sv
// Purpose: mode 0 bus master for the serial flash, one byte per request
// Assumes: software raises select before the first byte
// Notes: sck derived from i_mclk by a half-period divider
`timescale 1ns/10ps
`default_nettype none
module spi_flash_master
	import spi_flash_pkg::*;
#(
	parameter int HALF = SCK_HALF_CYCLES
)(
	// clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_reset_n,
	// register port
	input  wire logic [1:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic [7:0]      o_rdata,
	// serial pins
	spi_flash_if.host       spi
);
	initial
	begin
		if (HALF < 4 || HALF > 255)
			$error("HALF out of range");
	end

	// ==========================================================
	// state
	typedef enum logic {
		ST_IDLE  = 1'b0,
		ST_SHIFT = 1'b1
	} mstate_t;

	typedef struct packed {
		mstate_t    st;
		logic [7:0] half_cnt;
		logic [2:0] bit_cnt;
		logic [7:0] tx;
		logic [7:0] rx;
		logic [2:0] ctrl;
		logic       done;
		logic       sck;
		logic       si;
		logic       ce_n;
		logic       hold_n;
		logic       so_m, so_s;
		logic [7:0] rdata;
	} state_t;

	state_t q, d;

	always_comb
	begin
		d = q;
		d.so_m  = spi.so_line;
		d.so_s  = q.so_m;
		d.rdata = 8'h00;

		if (i_wr && i_addr == REG_CTRL)
			d.ctrl = i_wdata[2:0];
		else if (i_wr && i_addr == REG_DATA && q.st == ST_IDLE)
		begin
			d.tx       = i_wdata;
			d.si       = i_wdata[7];
			d.bit_cnt  = 3'h0;
			d.half_cnt = 8'h00;
			d.st       = ST_SHIFT;
		end

		if (i_rd && i_addr == REG_CTRL)
			d.rdata = {5'h00, q.ctrl};
		else if (i_rd && i_addr == REG_DATA)
		begin
			d.rdata = q.rx;
			d.done  = 1'b0;
		end
		else if (i_rd && i_addr == REG_STATUS)
			d.rdata = {6'h00, q.done, q.st == ST_SHIFT};

		case (q.st)
			ST_IDLE:
				d.sck = 1'b0;
			ST_SHIFT:
				// clock frozen low while pausing
				if (q.ctrl[CTRL_HOLD] && !q.sck)
					d.half_cnt = 8'h00;
				else if (q.half_cnt == 8'(HALF - 1))
				begin
					d.half_cnt = 8'h00;
					d.sck      = !q.sck;
					if (!q.sck)
						d.rx = {q.rx[6:0], q.so_s};
					else if (q.bit_cnt == 3'h7)
					begin
						d.st   = ST_IDLE;
						d.done = 1'b1; // set wins over a read clear
					end
					else
					begin
						d.bit_cnt = q.bit_cnt + 3'h1;
						d.tx      = {q.tx[6:0], 1'b0};
						d.si      = q.tx[6];
					end
				end
				else
					d.half_cnt = q.half_cnt + 8'h01;
			default:
				d.st = ST_IDLE;
		endcase

		// select stays low for the whole pause
		d.ce_n   = !(q.ctrl[CTRL_SEL] || q.ctrl[CTRL_HOLD]);
		d.hold_n = !q.ctrl[CTRL_HOLD];
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
		begin
			q        <= '0;
			q.ctrl   <= CTRL_RESET;
			q.ce_n   <= 1'b1;
			q.hold_n <= 1'b1;
		end
		else
			q <= d;
	end

	// ==========================================================
	// outputs
	assign o_rdata    = q.rdata;
	assign spi.sck    = q.sck;
	assign spi.si     = q.si;
	assign spi.ce_n   = q.ce_n;
	assign spi.hold_n = q.hold_n;
	assign spi.wp_n   = q.ctrl[CTRL_WP];
endmodule : spi_flash_master
`default_nettype wire

//--- verif/spi_flash_checker.sv
// Purpose: pin checks on the serial link between master and slave
// Assumes: master runs sck mode 0
// Notes: sees the interface pins only
`timescale 1ns/10ps
`default_nettype none
module spi_flash_checker
(
	// clock and reset
	input  wire logic i_mclk,
	input  wire logic i_reset_n,
	// serial pins
	input  wire logic sck,
	input  wire logic ce_n,
	input  wire logic si,
	input  wire logic so,
	input  wire logic so_oe,
	input  wire logic hold_n,
	input  wire logic wp_n
);
	// ==========================================================
	// sck rises seen in the current frame
	logic       sck_q;
	logic [2:0] rise_q;
	always_ff @(posedge i_mclk)
	begin
		sck_q <= sck;
		if (!i_reset_n || ce_n)
			rise_q <= 3'h0;
		else if (sck && !sck_q)
			rise_q <= rise_q + 3'h1;
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	// ==========================================================
	// assertions
	AST_SO_STANDS: assert property (so_oe && sck |-> $stable(so))
		else $error("serial out moved while sck high");
	AST_SI_SCK_LOW: assert property ($changed(si) |-> !sck)
		else $error("serial in moved while sck high");
	AST_SO_OE_START: assert property ($rose(so_oe) |-> !ce_n && !sck)
		else $error("serial out enabled outside a low sck");
	AST_IDLE_LOW: assert property (ce_n |-> !sck)
		else $error("sck high while deselected");
	AST_CE_SCK_LOW: assert property ($changed(ce_n) |-> !sck)
		else $error("select moved while sck high");
	AST_DESELECT_RELEASE: assert property (ce_n [*8] |-> !so_oe)
		else $error("serial out driven while deselected");
	AST_PAUSE_RELEASE: assert property ((!hold_n && !sck) [*8] |-> !so_oe)
		else $error("serial out driven while paused");
	AST_HOLD_SELECTED: assert property (!hold_n |-> !ce_n)
		else $error("pause raised without select");
	AST_WHOLE_BYTES: assert property ($rose(ce_n) |-> rise_q == 3'h0)
		else $error("frame ended inside a byte");
	// ==========================================================
	// covers
	cover property ($rose(so_oe));
	cover property (!hold_n && !ce_n);
	cover property ($rose(ce_n) && !wp_n);
endmodule : spi_flash_checker
`default_nettype wire

//--- verif/test_spi_flash_hold_and_write_protect.sv
// Purpose: bench for the flash slave and its master back to back
// Assumes: master in mode 0, slave busy time lengthened
// Notes: reads and started operations checked from queues
`timescale 1ns/10ps
`default_nettype none
module test_spi_flash_hold_and_write_protect;
	import spi_flash_pkg::*;
	// ==========================================================
	// signals
	logic        i_mclk;
	logic        i_reset_n;
	logic [1:0]  i_addr;
	logic [7:0]  i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [7:0]  o_rdata;
	logic [7:0]  o_status;
	logic        o_paused;
	logic        o_op_valid;
	op_kind_t    o_op_kind;
	logic [15:0] o_op_addr;
	logic [7:0]  o_op_data;
	logic        rd_q;
	logic        wp;
	logic [8:0]  rd_e[$];
	logic [26:0] op_e[$];
	logic [8:0]  e;
	logic [15:0] a;
	logic [7:0]  d;
	int          n_mismatch;
	int          compares;
	int          k;
	spi_flash_if spi_bus ();
	spi_flash_master u_spi_flash_master (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.spi(spi_bus));
	// long enough to poll status while busy
	spi_flash_slave #(.OP_CYCLES(1500)) u_spi_flash_slave (.i_mclk(i_mclk),
		.i_reset_n(i_reset_n), .spi(spi_bus), .o_status(o_status), .o_paused(o_paused),
		.o_op_valid(o_op_valid), .o_op_kind(o_op_kind), .o_op_addr(o_op_addr),
		.o_op_data(o_op_data));
	spi_flash_checker u_spi_flash_checker (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.sck(spi_bus.sck), .ce_n(spi_bus.ce_n), .si(spi_bus.si), .so(spi_bus.so),
		.so_oe(spi_bus.so_oe), .hold_n(spi_bus.hold_n), .wp_n(spi_bus.wp_n));
	initial
	begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end
	// ==========================================================
	// compares and verdict
	task automatic cmp_byte(input string n, input logic [7:0] x, input logic [7:0] y);
		compares++;
		if (y !== x)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", n, x, y);
		end
	endtask : cmp_byte
	task automatic cmp_op;
		logic [26:0] x;
		x = (op_e.size() == 0) ? 27'h7FFFFFF : op_e.pop_front();
		compares++;
		if (o_op_kind !== x[26:24] || (x[26:24] !== OPK_CHIP && o_op_addr !== x[23:8])
			|| (x[26:24] === OPK_PROG && o_op_data !== x[7:0]))
		begin
			n_mismatch++;
			$display("wrong value operation expected %h seen %h", x,
				{o_op_kind, o_op_addr, o_op_data});
		end
	endtask : cmp_op
	task automatic results;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	task automatic fail;
		n_mismatch++;
		results();
	endtask : fail
	// ==========================================================
	// register port and serial frames
	task automatic wr(input logic [1:0] ad, input logic [7:0] dt);
		i_addr <= ad;
		i_wdata <= dt;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		@(posedge i_mclk);
	endtask : wr
	task automatic rd(input logic [1:0] ad, input logic [8:0] ex, output logic [7:0] v);
		rd_e.push_back(ex);
		i_addr <= ad;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
		@(posedge i_mclk);
	endtask : rd
	task automatic xb(input logic [7:0] b, input logic [8:0] ex);
		logic [7:0] v;
		int i;
		wr(REG_DATA, b);
		for (i = 0; i < 400; i++)
		begin
			rd(REG_STATUS, 9'h000, v);
			if (v[STAT_DONE] === 1'b1)
				break;
		end
		if (i == 400)
			fail();
		rd(REG_DATA, ex, v);
	endtask : xb
	// pause between bytes, where sck rests low
	task automatic pause;
		wr(REG_CTRL, {5'h00, wp, 2'h3});
		repeat (40) @(posedge i_mclk);
		cmp_byte("paused", 8'h01, {7'h00, o_paused});
		wr(REG_CTRL, {5'h00, wp, 2'h1});
		repeat (40) @(posedge i_mclk);
		cmp_byte("paused", 8'h00, {7'h00, o_paused});
	endtask : pause
	task automatic frame(input int n, input logic [39:0] b, input logic [8:0] ex, input logic h);
		int i;
		wr(REG_CTRL, {5'h00, wp, 2'h1});
		for (i = 0; i < n; i++)
		begin
			if (h && i == 1)
				pause();
			xb(b[39 - 8 * i -: 8], (i == n - 1) ? ex : 9'h000);
		end
		wr(REG_CTRL, {5'h00, wp, 2'h0});
		repeat (12) @(posedge i_mclk);
	endtask : frame
	task automatic st(input logic [7:0] x);
		frame(2, {OP_RD_STAT, 32'h0}, {1'b1, x}, 1'b0);
	endtask : st
	task automatic cm(input int n, input logic [39:0] b);
		frame(n, b, 9'h000, 1'b0);
	endtask : cm
	task automatic idle;
		int i;
		for (i = 0; i < 3000; i++)
		begin
			@(posedge i_mclk);
			if (o_status[ST_BUSY] === 1'b0)
				break;
		end
		if (i == 3000)
			fail();
	endtask : idle
	task automatic op(input int n, input logic [39:0] b, input logic [26:0] x, input logic hit);
		cm(1, {OP_WR_EN, 32'h0});
		if (hit)
			op_e.push_back(x);
		cm(n, b);
		idle();
	endtask : op
	// ==========================================================
	// result watcher
	always @(posedge i_mclk)
	begin
		rd_q <= i_rd;
		if (rd_q === 1'b1)
		begin
			e = rd_e.pop_front();
			if (e[8])
				cmp_byte("read data", e[7:0], o_rdata);
		end
		if (o_op_valid === 1'b1)
			cmp_op();
	end
	// ==========================================================
	// scenarios
	initial
	begin
		i_reset_n = 1'b0;
		i_addr = 2'h0;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		wp = 1'b0;
		n_mismatch = 0;
		compares = 0;
		k = $urandom(32'hEFFF92BB);
		repeat (12) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		repeat (4) @(posedge i_mclk);
		st(8'h0C);
		cm(1, {OP_WR_EN, 32'h0});
		st(8'h0E);
		cm(1, {OP_WR_DIS, 32'h0});
		st(8'h0C);
		cm(2, {OP_WR_STAT, 8'h00, 24'h0});
		st(8'h00);
		a = 16'($urandom);
		cm(5, {OP_BYTE_PROG, 8'h00, a, 8'h5A});
		cm(2, {OP_WR_STAT, 8'h84, 24'h0});
		st(8'h84);
		cm(2, {OP_WR_STAT, 8'h00, 24'h0});
		st(8'h84);
		op(1, {OP_CHIP_ERA, 32'h0}, 27'h0, 1'b0);
		op(5, {OP_BYTE_PROG, 8'h00, a | 16'hC000, 8'hA5}, 27'h0, 1'b0);
		op(4, {OP_SECT_ERA, 8'h00, a | 16'hC000, 8'h00}, 27'h0, 1'b0);
		cm(1, {OP_WR_DIS, 32'h0});
		op(5, {OP_BYTE_PROG, 8'h00, a & 16'h7FFF, 8'hA5}, {OPK_PROG, a & 16'h7FFF, 8'hA5}, 1'b1);
		st(8'h84);
		op(4, {OP_BLK_ERA, 8'h00, a, 8'h00}, {OPK_BLOCK, a & 16'h8000, 8'h00}, 1'b1);
		wp <= 1'b1;
		cm(2, {OP_WR_STAT, 8'h00, 24'h0});
		st(8'h00);
		for (k = 0; k < 3; k++)
		begin
			a = 16'($urandom);
			d = 8'($urandom);
			op(4, {OP_SECT_ERA, 8'h00, a, 8'h00}, {OPK_SECT, a & 16'hF000, 8'h00}, 1'b1);
			op(5, {OP_BYTE_PROG, 8'h00, a, d}, {OPK_PROG, a, d}, 1'b1);
		end
		cm(1, {OP_WR_EN, 32'h0});
		op_e.push_back({OPK_CHIP, 24'h0});
		cm(1, {OP_CHIP_ERA, 32'h0});
		st(8'h03);
		idle();
		st(8'h00);
		frame(2, {OP_RD_STAT, 32'h0}, 9'h100, 1'b1);
		rd(2'h3, 9'h100, d);
		repeat (4) @(posedge i_mclk);
		cmp_byte("operations left", 8'h00, 8'(op_e.size()));
		results();
	end
endmodule : test_spi_flash_hold_and_write_protect
`default_nettype wire
